// File: verilog/lcd_pkg.sv
// Package for the lock-detect fault block: register map, field layout,
// threshold tables, timing counts and shared types.
// Assumes a 200 MHz clock and a simple strobe register port.
package lcd_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS       = 5;
  localparam int DEGLITCH_UNIT_NS    = 1000;
  localparam int DEGLITCH_UNIT_CYC   = DEGLITCH_UNIT_NS / CLK_PERIOD_NS;
  localparam int LOCK_RETRY_US       = 100;
  localparam int LOCK_RETRY_CYC      = LOCK_RETRY_US * 1000 / CLK_PERIOD_NS;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_MASK    = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_STATE   = 8'h10;

  // Reset values
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;
  localparam logic [2:0]  MASK_RESET   = 3'h0;

  // Configuration field positions
  localparam int F_ABSENT_EN   = 28;
  localparam int F_ABSENT_THR  = 19;
  localparam int F_LOCK_RESP   = 15;
  localparam int F_LOCK_DEG    = 12;
  localparam int F_RESERVED    = 11;
  localparam int F_MIN_SUPPLY  = 8;
  localparam int F_UV_RECOVER  = 7;
  localparam int F_RETRY_LIMIT = 0;

  // Status bit positions
  localparam int S_LOCK   = 0;
  localparam int S_ABSENT = 1;
  localparam int S_UV     = 2;

  // Control bit: clear latched faults
  localparam int C_CLEAR = 0;

  // Lock response codes
  localparam logic [3:0] RESP_RETRY_BASE = 4'h4;
  localparam logic [3:0] RESP_DISABLED   = 4'h8;

  // Current thresholds in 1/1024 A
  localparam logic [11:0] ABSENT_THR_TAB [8] = '{12'h020, 12'h030, 12'h040, 12'h050,
                                                12'h0A0, 12'h140, 12'h1E0, 12'h280};
  // Supply thresholds in mV, code 0 means no limit
  localparam logic [15:0] MIN_SUPPLY_TAB [8] = '{16'h0000, 16'h1194, 16'h1388, 16'h157C,
                                                16'h1770, 16'h1D4C, 16'h2710, 16'h30D4};
  // Retry limits, code 0 means unlimited
  localparam logic [4:0] RETRY_LIMIT_TAB [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
                                                5'h07, 5'h0A, 5'h0F, 5'h14};

  // Gate driver commands
  typedef enum logic [2:0] {
    GATE_NORMAL   = 3'b000,
    GATE_TRISTATE = 3'b100,
    GATE_RECIRC   = 3'b101,
    GATE_HS_BRAKE = 3'b110,
    GATE_LS_BRAKE = 3'b111
  } lcd_gate_t;

  // Lock fault states
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_RETRY   = 2'b01,
    ST_LATCHED = 2'b10
  } lcd_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lcd_bus_t;

  // Analog front-end measurements
  typedef struct packed {
    logic        over_limit;
    logic [11:0] phase_current;
    logic [15:0] supply_mv;
    logic        motor_running;
  } lcd_sense_t;

endpackage

// File: verilog/lcd_fault.sv
// Lock-detect and supply fault logic with its register file.
// Assumes sense inputs are synchronous to clock; the register master
// follows the one-cycle strobe protocol and never waits.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps

// Operation
// - Absent-motor threshold from bits 21:19
// - Lock response field at bits 18:15
// - Codes 0-3 latch fault, drive gate
// - Codes 4-7 auto-clear after retry time
// - Latch once retries exceed limit
// - Code 8 disables current-limit lock
// - Deglitch bits 14:12, N microseconds
// - Bit 11 reserved, read/write, reset zero
// - Minimum run supply bits 10:8
// - Retry limit codes, zero unlimited
// - Undervoltage latches or auto-clears per bit
// - Absent-motor check only when enabled
module lcd_fault
  import lcd_pkg::*;
#(
  parameter int RETRY_CYCLES = LOCK_RETRY_CYC
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Sense inputs
  input  wire logic        over_limit,
  input  wire logic [11:0] phase_current,
  input  wire logic [15:0] supply_mv,
  input  wire logic        motor_running,
  // Fault outputs
  output lcd_gate_t        gate_command,
  output logic             fault_indicator_n,
  output logic             irq
);

  // Whole module state
  typedef struct packed {
    logic [31:0] cfg;
    logic [2:0]  sts;
    logic [2:0]  mask;
    logic [31:0] rdata;
    lcd_state_t  st;
    logic [10:0] deg_cnt;
    logic        over_seen;
    logic [23:0] retry_tmr;
    logic [4:0]  retry_num;
    logic        absent_flt;
    logic        uv_flt;
    lcd_gate_t   gate;
    logic        fault_n;
  } lcd_regs_t;

  lcd_regs_t   s_r;        // Registered state
  lcd_regs_t   s_nxt;      // Next state
  logic [1:0]  rst_sync_r; // Reset release chain
  logic        rst_n;      // Synchronised reset
  lcd_bus_t    bus;        // Bundled request
  lcd_sense_t  sense;      // Bundled measurements

  assign bus   = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign sense = '{over_limit: over_limit, phase_current: phase_current,
                   supply_mv: supply_mv, motor_running: motor_running};
  assign rst_n = rst_sync_r[1];

  // Reset release through two flops; assert is asynchronous
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // Retry timer width is fixed, so clip the parameter once
  localparam logic [23:0] RETRY_LAST = 24'(RETRY_CYCLES - 1);

  // Decoded configuration fields
  logic [2:0]  thr_code;     // Absent-motor threshold code
  logic [3:0]  resp;         // Lock response code
  logic [2:0]  deg_code;     // Deglitch code
  logic [2:0]  vmin_code;    // Minimum supply code
  logic [2:0]  limit_code;   // Retry limit code
  logic [10:0] deg_target;   // Deglitch length in cycles
  logic        lock_hit;     // Deglitched lock detection
  logic        absent_hit;   // Absent-motor condition
  logic        uv_hit;       // Supply below run minimum
  logic [2:0]  events;       // Event pulses for status
  logic [2:0]  w1c;          // Status bits cleared by write
  logic        sw_clear;     // Clear latched faults
  lcd_gate_t   lock_gate;    // Gate action of lock fault

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    thr_code   = s_r.cfg[F_ABSENT_THR +: 3];
    resp       = s_r.cfg[F_LOCK_RESP +: 4];
    deg_code   = s_r.cfg[F_LOCK_DEG +: 3];
    vmin_code  = s_r.cfg[F_MIN_SUPPLY +: 3];
    limit_code = s_r.cfg[F_RETRY_LIMIT +: 3];
    deg_target = 11'(deg_code * DEGLITCH_UNIT_CYC);
    lock_hit   = 1'b0;
    events     = 3'h0;
    w1c        = 3'h0;
    sw_clear   = 1'b0;

    // Register writes; bit 11 is plain storage
    if (bus.wr)
    begin
      case (bus.addr)
        OFS_CONFIG:  s_nxt.cfg  = bus.wdata;
        OFS_STATUS:  w1c        = bus.wdata[2:0];
        OFS_MASK:    s_nxt.mask = bus.wdata[2:0];
        OFS_CONTROL: sw_clear   = bus.wdata[C_CLEAR];
        default:     ;
      endcase
    end

    if (!sense.over_limit || resp == RESP_DISABLED)
    begin
      // Drop restarts the window
      s_nxt.deg_cnt   = 11'h000;
      s_nxt.over_seen = 1'b0;
    end
    else if (!s_r.over_seen)
    begin
      // Code 0 means the first sample fires
      if (s_r.deg_cnt >= deg_target)
      begin
        lock_hit        = 1'b1;
        s_nxt.over_seen = 1'b1;
      end
      else
        s_nxt.deg_cnt = s_r.deg_cnt + 11'h001;
    end

    // Gate action from low bits of the response code
    case (resp[1:0])
      2'b00:   lock_gate = GATE_TRISTATE;
      2'b01:   lock_gate = GATE_RECIRC;
      2'b10:   lock_gate = GATE_HS_BRAKE;
      2'b11:   lock_gate = GATE_LS_BRAKE;
      default: lock_gate = GATE_TRISTATE;
    endcase

    // Lock fault sequencing
    case (s_r.st)
      ST_RUN:
      begin
        if (lock_hit)
        begin
          events[S_LOCK] = 1'b1;
          if (resp < RESP_RETRY_BASE)
            s_nxt.st = ST_LATCHED;
          else if (resp < RESP_DISABLED && limit_code != 3'h0 &&
                   s_r.retry_num >= RETRY_LIMIT_TAB[limit_code])
            s_nxt.st = ST_LATCHED;
          else if (resp < RESP_DISABLED)
          begin
            s_nxt.st        = ST_RETRY;
            s_nxt.retry_tmr = 24'h000000;
          end
        end
      end
      ST_RETRY:
      begin
        if (s_r.retry_tmr >= RETRY_LAST)
        begin
          s_nxt.st = ST_RUN;
          if (s_r.retry_num != 5'h1F)
            s_nxt.retry_num = s_r.retry_num + 5'h01;
        end
        else
          s_nxt.retry_tmr = s_r.retry_tmr + 24'h000001;
      end
      ST_LATCHED:
      begin
        // Only software releases a latched lock
        if (sw_clear)
        begin
          s_nxt.st        = ST_RUN;
          s_nxt.retry_num = 5'h00;
        end
      end
      default: s_nxt.st = ST_RUN;
    endcase

    absent_hit = s_r.cfg[F_ABSENT_EN] && sense.motor_running &&
                 (sense.phase_current < ABSENT_THR_TAB[thr_code]);
    if (absent_hit && !s_r.absent_flt)
      events[S_ABSENT] = 1'b1;
    if (absent_hit)
      s_nxt.absent_flt = 1'b1;
    else if (sw_clear)
      s_nxt.absent_flt = 1'b0;

    // no limit when code is zero
    uv_hit = (vmin_code != 3'h0) && (sense.supply_mv < MIN_SUPPLY_TAB[vmin_code]);
    if (uv_hit && !s_r.uv_flt)
      events[S_UV] = 1'b1;
    if (uv_hit)
      s_nxt.uv_flt = 1'b1;
    else if (s_r.cfg[F_UV_RECOVER] || sw_clear)
      s_nxt.uv_flt = 1'b0;

    // Sticky status; a new event beats a same-cycle clear
    s_nxt.sts = (s_r.sts & ~w1c) | events;

    // Gate command: lock action first, supply loss tristates
    if (s_nxt.st != ST_RUN)
      s_nxt.gate = lock_gate;
    else if (s_nxt.uv_flt)
      s_nxt.gate = GATE_TRISTATE;
    else
      s_nxt.gate = GATE_NORMAL;

    // fault indication while any fault stands
    s_nxt.fault_n = !((s_nxt.st != ST_RUN) || s_nxt.uv_flt || s_nxt.absent_flt);

    // Read data valid in the cycle after the strobe only
    s_nxt.rdata = 32'h00000000;
    if (bus.rd)
    begin
      case (bus.addr)
        OFS_CONFIG: s_nxt.rdata = s_r.cfg;
        OFS_STATUS: s_nxt.rdata = {29'h0, s_r.sts};
        OFS_MASK:   s_nxt.rdata = {29'h0, s_r.mask};
        OFS_STATE:  s_nxt.rdata = {19'h0, s_r.retry_num, 3'(s_r.gate), s_r.uv_flt,
                                   s_r.absent_flt, s_r.st, s_r.fault_n};
        default:    s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r            <= '0;
      s_r.cfg        <= CONFIG_RESET;
      s_r.mask       <= MASK_RESET;
      s_r.st         <= ST_RUN;
      s_r.gate       <= GATE_NORMAL;
      s_r.fault_n    <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs
  assign reg_rdata         = s_r.rdata;
  assign gate_command      = s_r.gate;
  assign fault_indicator_n = s_r.fault_n;
  assign irq               = |(s_r.sts & s_r.mask);

endmodule

// File: verif/lcd_motor_model.sv
// Motor-side model for the lock-detect fault block.
// Assumes the bench steers stall, absence and supply level.
`timescale 1ns/10ps
module lcd_motor_model
  import lcd_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Bench controls
  input  wire logic        stall,
  input  wire logic        absent,
  input  wire logic [15:0] supply_set,
  // Bridge command
  input  wire lcd_gate_t   gate_command,
  // Measurements
  output lcd_sense_t       sense
);
  // Quiet measurements before the first edge
  initial sense = '0;

  // Stall current collapses once the bridge stops driving
  always @(posedge clock)
  begin
    sense.over_limit    <= stall && (gate_command == GATE_NORMAL);
    sense.phase_current <= absent ? 12'h010 : 12'h300;
    sense.supply_mv     <= supply_set;
    sense.motor_running <= (gate_command == GATE_NORMAL);
  end
endmodule

// File: verif/lcd_fault_chk.sv
// Port checker for the lock-detect fault block.
// Assumes one clock domain and the strobe register port.
`timescale 1ns/10ps
module lcd_fault_chk
  import lcd_pkg::*;
#(
  parameter int RETRY_CYCLES = LOCK_RETRY_CYC
)
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sense and fault side
  input wire logic        over_limit,
  input wire logic [11:0] phase_current,
  input wire logic [15:0] supply_mv,
  input wire lcd_gate_t   gate_command,
  input wire logic        fault_indicator_n,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_gate_fault: assert property (gate_command != GATE_NORMAL |-> !fault_indicator_n)
    else $error("bridge action without fault");
  a_gate_legal: assert property (gate_command inside {GATE_NORMAL, GATE_TRISTATE,
    GATE_RECIRC, GATE_HS_BRAKE, GATE_LS_BRAKE}) else $error("bad bridge code");
  a_cfg_readback: assert property (reg_wr && reg_addr == OFS_CONFIG ##1
    reg_rd && reg_addr == OFS_CONFIG |=> reg_rdata == $past(reg_wdata, 2))
    else $error("config readback differs");
  a_unmapped_read: assert property (reg_rd && reg_addr > OFS_STATE |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  a_lock_cause: assert property ($fell(fault_indicator_n) && $past(supply_mv) >= 16'h30D4
    && $past(phase_current) >= 12'h280 |-> $past(over_limit, 2))
    else $error("lock without over-limit");
  a_irq_masked: assert property (reg_wr && reg_addr == OFS_MASK
    && reg_wdata[2:0] == 3'h0 |=> !irq) else $error("irq despite zero mask");
  a_state_mirror: assert property (reg_rd && reg_addr == OFS_STATE |=>
    reg_rdata[0] == $past(fault_indicator_n) && reg_rdata[7:5] == $past(gate_command))
    else $error("state read mismatch");

  // Main scenarios reached
  c_lock: cover property ($fell(fault_indicator_n));
  c_irq: cover property ($rose(irq));
  c_recover: cover property ($rose(fault_indicator_n));
endmodule

bind lcd_fault lcd_fault_chk #(.RETRY_CYCLES(RETRY_CYCLES)) i_lcd_fault_chk (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .over_limit(over_limit),
  .phase_current(phase_current), .supply_mv(supply_mv), .gate_command(gate_command),
  .fault_indicator_n(fault_indicator_n), .irq(irq));

// File: verif/test_lcd_fault.sv
// Testbench for the lock-detect fault block.
// Assumes a short retry time and a motor model on the sense side.
`timescale 1ns/10ps
module test_lcd_fault
  import lcd_pkg::*;
;
  localparam int RC = 50;            // Shortened retry span
  logic        clock, resetn, reg_wr, reg_rd, stall, absent;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] supply_set;
  lcd_sense_t  sense;
  lcd_gate_t   gate_command;
  logic        fault_indicator_n, irq;
  int          miscompares, n_tests, n;
  lcd_gate_t   gtab [4] = '{GATE_TRISTATE, GATE_RECIRC, GATE_HS_BRAKE, GATE_LS_BRAKE};

  lcd_fault #(.RETRY_CYCLES(RC)) i_lcd_fault (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .over_limit(sense.over_limit), .phase_current(sense.phase_current),
    .supply_mv(sense.supply_mv), .motor_running(sense.motor_running),
    .gate_command(gate_command), .fault_indicator_n(fault_indicator_n), .irq(irq));
  lcd_motor_model i_lcd_motor_model (.clock(clock), .stall(stall), .absent(absent),
    .supply_set(supply_set), .gate_command(gate_command), .sense(sense));

  // Free-running clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Optional write, then read with no gap
  task automatic rd(input logic [7:0] a, input logic w, input logic [31:0] v);
    if (w)
      wr(a, v);
    else
      @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // Bounded wait for a fault level, settled sampling
  task automatic wait_n(input logic lvl);
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (fault_indicator_n !== lvl && n < 400);
  endtask

  task automatic clear_all();
    wr(OFS_CONTROL, 32'h1);
    wr(OFS_STATUS, 32'h7);
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #(60000 * 5);
    miscompares++;
    results();
  end

  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, stall, absent, miscompares, n_tests} = '0;
    supply_set = 16'h5DC0;
    resetn = 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFS_CONFIG, 0, 0); check("config reset", d, CONFIG_RESET);
    rd(OFS_MASK, 0, 0); check("mask reset", d, 32'(MASK_RESET));
    rd(8'h40, 0, 0); check("unmapped", d, 32'h0);
    rd(OFS_CONFIG, 1, 32'h103FFF87); check("fields", d, 32'h103FFF87);
    rd(OFS_CONFIG, 1, 32'h002A8805); check("fields", d, 32'h002A8805);
    $display("done: registers");
    // Deglitch restart after a dropout
    wr(OFS_CONFIG, 32'h1 << F_LOCK_DEG);
    @(posedge clock) stall <= 1'b1;
    repeat (150) @(posedge clock);
    stall <= 1'b0;
    repeat (2) @(posedge clock);
    stall <= 1'b1;
    wait_n(1'b0); check("deglitch", n >= 199 && n <= 206, 1);
    @(posedge clock) stall <= 1'b0;
    clear_all();
    // Response codes 0-7, retry limit of two
    for (int c = 0; c < 8; c++)
    begin
      wr(OFS_CONFIG, (32'(c) << F_LOCK_RESP) | (32'h1 << F_LOCK_DEG) | 32'h1);
      @(posedge clock) stall <= 1'b1;
      for (int k = 0; k < ((c < 4) ? 1 : 3); k++)
      begin
        wait_n(1'b0); check("gate", gate_command, gtab[c % 4]);
        repeat (RC + 10) @(negedge clock);
        check("recover", fault_indicator_n, c > 3 && k < 2);
      end
      @(posedge clock) stall <= 1'b0;
      clear_all();
    end
    $display("done: lock codes");
    // Detection off, then interrupt path
    wr(OFS_CONFIG, 32'(RESP_DISABLED) << F_LOCK_RESP);
    @(posedge clock) stall <= 1'b1;
    repeat (300) @(negedge clock);
    check("disabled", fault_indicator_n, 1);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CONFIG, 32'h0);
    wait_n(1'b0); check("irq", irq, 1);
    @(posedge clock) stall <= 1'b0;
    rd(OFS_STATE, 0, 0); check("state", d[2:1], 2'h2);
    wr(OFS_MASK, 32'h0); @(negedge clock); check("masked", irq, 0);
    wr(OFS_MASK, 32'h1); clear_all(); @(negedge clock); check("cleared", irq, 0);
    $display("done: interrupt");
    // Undervoltage, latched and self-clearing
    for (int m = 0; m < 2; m++)
    begin
      wr(OFS_CONFIG, (32'h7 << F_MIN_SUPPLY) | (32'(m) << F_UV_RECOVER));
      @(posedge clock) supply_set <= 16'h30D3;
      wait_n(1'b0); check("uv gate", gate_command, GATE_TRISTATE);
      @(posedge clock) supply_set <= 16'h30D4;
      repeat (20) @(negedge clock);
      check("uv recover", fault_indicator_n, m);
      clear_all();
    end
    // Absent motor check on and off
    for (int m = 1; m >= 0; m--)
    begin
      wr(OFS_CONFIG, 32'(m) << F_ABSENT_EN);
      @(posedge clock) absent <= 1'b1;
      repeat (20) @(negedge clock);
      rd(OFS_STATUS, 0, 0); check("absent", d[S_ABSENT], m);
      @(posedge clock) absent <= 1'b0;
      clear_all();
    end
    $display("done: supply and absent motor");
    results();
  end
endmodule
